// File: design/tcs_timer_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.vh"

module tcs_timer_ctrl (
    // clock and reset
    input wire ref_clk,
    input wire arst_n,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output reg [31:0] hrdata,
    output wire hresp,
    // counter events, valid on cnt_tick
    input wire update_cond,
    input wire wrap_cond,
    input wire [15:0] count_in,
    output wire cnt_tick,
    // counter control
    output reg cnt_enable,
    output reg cnt_capture_en,
    output reg cnt_running,
    output reg cnt_retrigger,
    output reg cnt_stop,
    output reg cnt_soft_reset,
    output reg cnt_load,
    output reg [15:0] cnt_load_value,
    // active values
    output reg [2:0] wave_mode,
    output reg [15:0] period_value,
    output reg [15:0] compare_capture_value0,
    output reg [15:0] compare_capture_value1,
    output reg [7:0] pattern_output,
    output reg [7:0] pattern_value,
    output reg [3:0] output_swap,
    output reg cycle_select_flag
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release and counter tick
    reg rst_m_q;
    reg rst_n_q;
    wire rst_n;

    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end
    assign rst_n = rst_n_q;

    tcs_tick_div #(.DIV(`TCS_CNT_DIV)) u_div (
        .clk(ref_clk),
        .rst_n(rst_n),
        .tick(cnt_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave
    wire [5:0] a_word = haddr[7:2];
    wire a_mapped = (a_word <= `TCS_LAST_WORD) && (a_word != `TCS_BUSY_WORD);
    wire [3:0] a_slot = (a_word < `TCS_BUSY_WORD) ? a_word[3:0] : a_word[3:0] - 4'h1;
    wire a_go = hsel & htrans[1] & hready;
    reg dp_wr_q;
    reg [3:0] dp_slot_q;
    wire [`TCS_NSYNC-1:0] busy;
    wire [`TCS_NSYNC*32-1:0] sdata;
    wire [`TCS_NSYNC-1:0] strobe;
    // a write to a slot still crossing stalls instead of losing the older value
    wire wr_stall = dp_wr_q & busy[dp_slot_q];
    wire wr_go = dp_wr_q & ~wr_stall;

    assign hreadyout = ~wr_stall;
    assign hresp = 1'b0;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_wr_q <= 1'b0;
            dp_slot_q <= 4'h0;
        end
        else if (hreadyout)
        begin
            dp_wr_q <= a_go & hwrite & a_mapped;
            dp_slot_q <= a_slot;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `TCS_NSYNC; gi = gi + 1)
        begin : g_slot
            tcs_sync_slot #(.W(32)) u_slot (
                .clk(ref_clk),
                .rst_n(rst_n),
                .tick(cnt_tick),
                .wr(wr_go && (dp_slot_q == gi)),
                .wdata(hwdata),
                .busy(busy[gi]),
                .sdata(sdata[gi*32 +: 32]),
                .strobe(strobe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // counter-domain state
    reg lock_q;
    reg single_run_bit_q;
    reg [1:0] ramp_index_command_q;
    reg done_q;
    reg [15:0] count_rd_q;
    reg [7:0] output_pattern_oe_buf_q;
    reg [7:0] output_pattern_val_buf_q;
    reg [3:0] swap_buf_q;
    reg [15:0] per_buf_q;
    reg [15:0] cc0_buf_q;
    reg [15:0] cc1_buf_q;

    wire [31:0] w_control_a_reg = sdata[`TCS_S_CONTROL_A_REG*32 +: 32];
    wire [31:0] w_clr = sdata[`TCS_S_CLR*32 +: 32];
    wire [31:0] w_set = sdata[`TCS_S_SET*32 +: 32];
    wire [31:0] w_status = sdata[`TCS_S_STATUS*32 +: 32];
    wire [31:0] w_output_pattern = sdata[`TCS_S_OUTPUT_PATTERN*32 +: 32];
    wire [31:0] w_output_pattern_buffer = sdata[`TCS_S_OUTPUT_PATTERN_BUFFER*32 +: 32];
    wire [31:0] w_wave = sdata[`TCS_S_WAVE*32 +: 32];
    wire [31:0] w_count = sdata[`TCS_S_COUNT*32 +: 32];
    wire [31:0] w_per = sdata[`TCS_S_PER*32 +: 32];
    wire [31:0] w_period_value_buffer = sdata[`TCS_S_PERIOD_VALUE_BUFFER*32 +: 32];
    wire [31:0] w_cc0 = sdata[`TCS_S_CC0*32 +: 32];
    wire [31:0] w_ccbuf0 = sdata[`TCS_S_CCBUF0*32 +: 32];
    wire [31:0] w_cc1 = sdata[`TCS_S_CC1*32 +: 32];
    wire [31:0] w_ccbuf1 = sdata[`TCS_S_CCBUF1*32 +: 32];

    wire set_go = strobe[`TCS_S_SET];
    wire clr_go = strobe[`TCS_S_CLR];
    wire [2:0] cmd = set_go ? w_set[`TCS_CB_CMD_HI:`TCS_CB_CMD_LO] : `TCS_CMD_NONE;
    wire soft_reset_bit = strobe[`TCS_S_CONTROL_A_REG] & w_control_a_reg[`TCS_CA_SOFT_RESET_BIT];
    wire hw_upd = cnt_tick & update_cond;
    wire hw_wrap = cnt_tick & wrap_cond;
    wire dual_ramp = (wave_mode == `TCS_WAVE_DUAL_RAMP_MODE) || (wave_mode == `TCS_WAVE_DUAL_RAMP_ALT_MODE);
    wire copy_go = (hw_upd & (~lock_q | cnt_capture_en))
        | (cmd == `TCS_CMD_UPDATE);
    wire single_run_bit_end = hw_wrap & single_run_bit_q & cnt_running;

    ////////////////////////////////////////////////////////////////////////////
    // control bits: set and clear registers
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_q <= 1'b0;
            single_run_bit_q <= 1'b0;
            ramp_index_command_q <= `TCS_IDX_TOGGLE;
        end
        else if (soft_reset_bit)
        begin
            lock_q <= 1'b0;
            single_run_bit_q <= 1'b0;
            ramp_index_command_q <= `TCS_IDX_TOGGLE;
        end
        else
        begin
            if (clr_go && w_clr[`TCS_CB_LOCK])
                lock_q <= 1'b0;
            if (set_go && w_set[`TCS_CB_LOCK])
                lock_q <= 1'b1;
            if (clr_go && w_clr[`TCS_CB_SINGLE_RUN_BIT])
                single_run_bit_q <= 1'b0;
            if (set_go && w_set[`TCS_CB_SINGLE_RUN_BIT])
                single_run_bit_q <= 1'b1;
            // executed command clears, then a fresh write lands on top
            if (hw_upd && dual_ramp)
                ramp_index_command_q <= `TCS_IDX_TOGGLE;
            if (clr_go)
                ramp_index_command_q <= ramp_index_command_q & ~w_clr[`TCS_CB_IDX_HI:`TCS_CB_IDX_LO];
            if (set_go && (w_set[`TCS_CB_IDX_HI:`TCS_CB_IDX_LO] != `TCS_IDX_TOGGLE))
                ramp_index_command_q <= w_set[`TCS_CB_IDX_HI:`TCS_CB_IDX_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run control, commands and cycle index
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_enable <= 1'b0;
            cnt_capture_en <= 1'b0;
            cnt_running <= 1'b0;
            cnt_retrigger <= 1'b0;
            cnt_stop <= 1'b0;
            cnt_soft_reset <= 1'b0;
            cnt_load <= 1'b0;
            cnt_load_value <= 16'h0000;
            count_rd_q <= 16'h0000;
            cycle_select_flag <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_soft_reset <= soft_reset_bit;
            cnt_retrigger <= (cmd == `TCS_CMD_RETRIG);
            cnt_stop <= (cmd == `TCS_CMD_STOP) | single_run_bit_end;
            cnt_load <= strobe[`TCS_S_COUNT];
            if (strobe[`TCS_S_COUNT])
                cnt_load_value <= w_count[15:0];
            if (cmd == `TCS_CMD_RDSYNC)
                count_rd_q <= count_in;
            if (soft_reset_bit)
            begin
                cnt_enable <= 1'b0;
                cnt_capture_en <= 1'b0;
                cnt_running <= 1'b0;
                cycle_select_flag <= 1'b0;
                done_q <= 1'b0;
            end
            else
            begin
                if (strobe[`TCS_S_CONTROL_A_REG])
                begin
                    cnt_enable <= w_control_a_reg[`TCS_CA_ENABLE];
                    cnt_capture_en <= w_control_a_reg[`TCS_CA_CAPTEN];
                    if (w_control_a_reg[`TCS_CA_ENABLE] && !cnt_enable)
                        cnt_running <= 1'b1;
                    if (!w_control_a_reg[`TCS_CA_ENABLE])
                        cnt_running <= 1'b0;
                end
                // without one-shot a wrap leaves the counter running
                if (cmd == `TCS_CMD_STOP || single_run_bit_end)
                    cnt_running <= 1'b0;
                if (cmd == `TCS_CMD_RETRIG && cnt_enable)
                    cnt_running <= 1'b1;
                // done flag: software clear loses to a same-cycle one-shot wrap stop
                if (strobe[`TCS_S_STATUS] && w_status[`TCS_ST_DONE])
                    done_q <= 1'b0;
                if (single_run_bit_end)
                    done_q <= 1'b1;
                if (hw_upd && dual_ramp)
                begin
                    case (ramp_index_command_q)
                        `TCS_IDX_TOGGLE: cycle_select_flag <= ~cycle_select_flag;
                        `TCS_IDX_SET: cycle_select_flag <= 1'b1;
                        `TCS_IDX_CLEAR: cycle_select_flag <= 1'b0;
                        `TCS_IDX_HOLD: cycle_select_flag <= cycle_select_flag;
                        default: cycle_select_flag <= cycle_select_flag;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // double-buffered values, plus the unbuffered wave mode
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wave_mode <= 3'h0;
            period_value <= 16'hFFFF;
            per_buf_q <= 16'hFFFF;
            compare_capture_value0 <= 16'h0000;
            compare_capture_value1 <= 16'h0000;
            cc0_buf_q <= 16'h0000;
            cc1_buf_q <= 16'h0000;
            pattern_output <= 8'h00;
            pattern_value <= 8'h00;
            output_swap <= 4'h0;
            output_pattern_oe_buf_q <= 8'h00;
            output_pattern_val_buf_q <= 8'h00;
            swap_buf_q <= 4'h0;
        end
        else
        begin
            if (strobe[`TCS_S_WAVE])
                wave_mode <= w_wave[2:0];
            if (strobe[`TCS_S_PERIOD_VALUE_BUFFER])
                per_buf_q <= w_period_value_buffer[15:0];
            if (strobe[`TCS_S_CCBUF0])
                cc0_buf_q <= w_ccbuf0[15:0];
            if (strobe[`TCS_S_CCBUF1])
                cc1_buf_q <= w_ccbuf1[15:0];
            if (strobe[`TCS_S_OUTPUT_PATTERN_BUFFER])
            begin
                output_pattern_oe_buf_q <= w_output_pattern_buffer[7:0];
                output_pattern_val_buf_q <= w_output_pattern_buffer[15:8];
                swap_buf_q <= w_output_pattern_buffer[19:16];
            end
            // direct writes take priority over a buffer copy in the same cycle
            if (copy_go)
            begin
                period_value <= per_buf_q;
                compare_capture_value0 <= cc0_buf_q;
                compare_capture_value1 <= cc1_buf_q;
                pattern_output <= output_pattern_oe_buf_q;
                pattern_value <= output_pattern_val_buf_q;
                output_swap <= swap_buf_q;
            end
            if (strobe[`TCS_S_PER])
                period_value <= w_per[15:0];
            if (strobe[`TCS_S_CC0])
                compare_capture_value0 <= w_cc0[15:0];
            if (strobe[`TCS_S_CC1])
                compare_capture_value1 <= w_cc1[15:0];
            if (strobe[`TCS_S_OUTPUT_PATTERN])
            begin
                pattern_output <= w_output_pattern[7:0];
                pattern_value <= w_output_pattern[15:8];
                output_swap <= w_output_pattern[19:16];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, sampled in the address phase from counter-domain copies
    reg [31:0] rd_mux;

    always @*
    begin
        rd_mux = 32'h00000000;
        case (haddr)
            `TCS_OFF_CONTROL_A_REG: rd_mux = {29'h0, cnt_capture_en, cnt_enable, 1'b0};
            `TCS_OFF_CMD_CLR,
            `TCS_OFF_CMD_SET: rd_mux = {24'h0, 3'h0, ramp_index_command_q, single_run_bit_q, lock_q, 1'b0};
            `TCS_OFF_SYNC_BUSY: rd_mux = {18'h0, busy};
            `TCS_OFF_STATUS: rd_mux = {29'h0, done_q, ~cnt_running, cycle_select_flag};
            `TCS_OFF_OUTPUT_PATTERN: rd_mux = {12'h0, output_swap, pattern_value, pattern_output};
            `TCS_OFF_OUTPUT_PATTERN_BUFFER: rd_mux = {12'h0, swap_buf_q, output_pattern_val_buf_q, output_pattern_oe_buf_q};
            `TCS_OFF_WAVE: rd_mux = {29'h0, wave_mode};
            `TCS_OFF_COUNT: rd_mux = {16'h0, count_rd_q};
            `TCS_OFF_PER: rd_mux = {16'h0, period_value};
            `TCS_OFF_PERIOD_VALUE_BUFFER: rd_mux = {16'h0, per_buf_q};
            `TCS_OFF_CC0: rd_mux = {16'h0, compare_capture_value0};
            `TCS_OFF_CCBUF0: rd_mux = {16'h0, cc0_buf_q};
            `TCS_OFF_CC1: rd_mux = {16'h0, compare_capture_value1};
            `TCS_OFF_CCBUF1: rd_mux = {16'h0, cc1_buf_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= 32'h00000000;
        else if (hreadyout && a_go && !hwrite)
            hrdata <= rd_mux;
    end
endmodule
`default_nettype wire

// File: shared/tcs_regs.vh
`ifndef TCS_REGS_VH
`define TCS_REGS_VH

// register byte offsets
`define TCS_OFF_CONTROL_A_REG 8'h00
`define TCS_OFF_CMD_CLR 8'h04
`define TCS_OFF_CMD_SET 8'h08
`define TCS_OFF_SYNC_BUSY 8'h0C
`define TCS_OFF_STATUS 8'h10
`define TCS_OFF_OUTPUT_PATTERN 8'h14
`define TCS_OFF_OUTPUT_PATTERN_BUFFER 8'h18
`define TCS_OFF_WAVE 8'h1C
`define TCS_OFF_COUNT 8'h20
`define TCS_OFF_PER 8'h24
`define TCS_OFF_PERIOD_VALUE_BUFFER 8'h28
`define TCS_OFF_CC0 8'h2C
`define TCS_OFF_CCBUF0 8'h30
`define TCS_OFF_CC1 8'h34
`define TCS_OFF_CCBUF1 8'h38
`define TCS_LAST_WORD 6'h0E
`define TCS_BUSY_WORD 6'h03

// synchronized register slots
`define TCS_NSYNC 14
`define TCS_S_CONTROL_A_REG 0
`define TCS_S_CLR 1
`define TCS_S_SET 2
`define TCS_S_STATUS 3
`define TCS_S_OUTPUT_PATTERN 4
`define TCS_S_OUTPUT_PATTERN_BUFFER 5
`define TCS_S_WAVE 6
`define TCS_S_COUNT 7
`define TCS_S_PER 8
`define TCS_S_PERIOD_VALUE_BUFFER 9
`define TCS_S_CC0 10
`define TCS_S_CCBUF0 11
`define TCS_S_CC1 12
`define TCS_S_CCBUF1 13

// control a fields
`define TCS_CA_SOFT_RESET_BIT 0
`define TCS_CA_ENABLE 1
`define TCS_CA_CAPTEN 2

// command set/clear fields
`define TCS_CB_LOCK 1
`define TCS_CB_SINGLE_RUN_BIT 2
`define TCS_CB_IDX_LO 3
`define TCS_CB_IDX_HI 4
`define TCS_CB_CMD_LO 5
`define TCS_CB_CMD_HI 7

// command codes
`define TCS_CMD_NONE 3'h0
`define TCS_CMD_RETRIG 3'h1
`define TCS_CMD_STOP 3'h2
`define TCS_CMD_UPDATE 3'h3
`define TCS_CMD_RDSYNC 3'h4

// ramp index commands
`define TCS_IDX_TOGGLE 2'h0
`define TCS_IDX_SET 2'h1
`define TCS_IDX_CLEAR 2'h2
`define TCS_IDX_HOLD 2'h3

// status fields
`define TCS_ST_IDX 0
`define TCS_ST_STOP 1
`define TCS_ST_DONE 2

// wave modes
`define TCS_WAVE_DUAL_RAMP_MODE 3'h4
`define TCS_WAVE_DUAL_RAMP_ALT_MODE 3'h5

// counter clock: ref_clk divided down
`define TCS_CNT_DIV 4
`define TCS_VAL_W 16

`endif

// File: design/tcs_tick_div.v
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable pulse every DIV clocks
module tcs_tick_div #(
    parameter DIV = 4
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // tick
    output reg tick
);
    reg [7:0] cnt_q;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 8'h00;
            tick <= 1'b0;
        end
        else if (cnt_q == DIV[7:0] - 8'h01)
        begin
            cnt_q <= 8'h00;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: design/tcs_sync_slot.v
`timescale 1ns/1ps
`default_nettype none
// bus write held busy until the next counter tick carries it across
module tcs_sync_slot #(
    parameter W = 32
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // counter-domain tick
    input wire tick,
    // bus side
    input wire wr,
    input wire [W-1:0] wdata,
    output reg busy,
    // counter side
    output reg [W-1:0] sdata,
    output reg strobe
);
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
            sdata <= {W{1'b0}};
            strobe <= 1'b0;
        end
        else
        begin
            strobe <= tick & busy;
            if (wr)
            begin
                sdata <= wdata;
                busy <= 1'b1;
            end
            else if (tick)
            begin
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tcs_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.vh"
module tcs_ctrl_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // counter side
    input wire logic cnt_tick,
    input wire logic cnt_enable,
    input wire logic cnt_running,
    input wire logic cnt_retrigger,
    input wire logic cnt_stop,
    input wire logic cnt_soft_reset,
    input wire logic cnt_load,
    input wire logic [2:0] wave_mode,
    input wire logic cycle_select_flag
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    logic rd_go;
    assign rd_go = hsel && htrans[1] && hready && !hwrite;
    ////////////////////////////////////////////////////////////////////////////////
    chk_tick_every_four: assert property (cnt_tick |=> !cnt_tick [*3] ##1 cnt_tick)
        else $error("counter tick spacing wrong");
    chk_stall_bounded: assert property (!hreadyout |-> ##[1:12] hreadyout)
        else $error("write stall too long");
    chk_read_no_wait: assert property (rd_go |=> hreadyout)
        else $error("read data phase stalled");
    chk_rdata_holds: assert property (!rd_go |=> $stable(hrdata))
        else $error("read data changed without a read");
    chk_retrig_pulse: assert property (cnt_retrigger |=> !cnt_retrigger)
        else $error("retrigger longer than one cycle");
    chk_stop_pulse: assert property (cnt_stop |=> !cnt_stop)
        else $error("stop longer than one cycle");
    chk_load_pulse: assert property (cnt_load |=> !cnt_load)
        else $error("count load longer than one cycle");
    chk_retrig_runs: assert property (cnt_retrigger && cnt_enable |-> ##[0:1] cnt_running)
        else $error("retrigger did not start counter");
    chk_stop_halts: assert property (cnt_stop |-> ##[0:1] !cnt_running)
        else $error("stop left counter running");
    chk_soft_reset_bit_clears: assert property (
        cnt_soft_reset |-> ##[0:1] !(cnt_enable || cnt_running))
        else $error("soft reset left counter enabled");
    chk_idx_dual_only: assert property ($changed(cycle_select_flag) |->
        wave_mode inside {`TCS_WAVE_DUAL_RAMP_MODE, `TCS_WAVE_DUAL_RAMP_ALT_MODE} || cnt_soft_reset
        || $past(cnt_soft_reset))
        else $error("cycle flag moved outside dual ramp");
endmodule
bind tcs_timer_ctrl tcs_ctrl_checker u_chk (
    .ref_clk, .arst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .cnt_tick,
    .cnt_enable, .cnt_running, .cnt_retrigger, .cnt_stop, .cnt_soft_reset, .wave_mode,
    .cycle_select_flag, .cnt_load
);
`default_nettype wire

// File: sim/tcs_timer_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_regs.vh"
module tcs_timer_ctrl_tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic update_cond = 1'b0;
    logic wrap_cond = 1'b0;
    logic [15:0] count_in = 16'h0000;
    logic hreadyout, hresp, cnt_tick, cnt_enable, cnt_capture_en, cnt_running, cycle_select_flag;
    logic [31:0] hrdata;
    logic [15:0] period_value, cc0, cc1, load_val;
    logic [7:0] pattern_output, pattern_value;
    logic [3:0] output_swap;
    logic [2:0] wave_mode;
    int err_total = 0;
    int n_checks = 0;
    logic [1:0] idx_code [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic idx_exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    always #2.5 ref_clk = ~ref_clk;

    tcs_timer_ctrl dut (
        .ref_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .update_cond, .wrap_cond, .count_in,
        .cnt_tick, .cnt_enable, .cnt_capture_en, .cnt_running, .cnt_retrigger(), .cnt_stop(),
        .cnt_soft_reset(), .cnt_load(), .cnt_load_value(load_val), .wave_mode, .period_value,
        .compare_capture_value0(cc0), .compare_capture_value1(cc1), .pattern_output,
        .pattern_value, .output_swap, .cycle_select_flag
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // sampled at the edge, before that edge's updates land
    task automatic wait_ready();
        int i;
        i = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1 && i < 50)
        begin
            @(posedge ref_clk);
            i++;
        end
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            conclude();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    // poll busy flags; the effect trails the flag by one cycle
    task automatic wr_s(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        int i;
        bus(a, 1'b1, d, q);
        for (i = 0; i < 40; i++)
        begin
            bus(`TCS_OFF_SYNC_BUSY, 1'b0, 32'h0, q);
            if (q[13:0] === 14'h0)
                break;
        end
        if (i == 40)
        begin
            err_total++;
            conclude();
        end
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check(what, exp, q);
    endtask

    // hold the event across exactly one counter tick
    task automatic fire(input logic upd);
        int i;
        for (i = 0; i < 8 && cnt_tick !== 1'b1; i++)
            @(posedge ref_clk);
        if (upd)
            update_cond <= 1'b1;
        else
            wrap_cond <= 1'b1;
        repeat (4) @(posedge ref_clk);
        update_cond <= 1'b0;
        wrap_cond <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] q;
        int k;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("per_reset", 32'hFFFF, {16'h0, period_value});
        bus(8'h3C, 1'b1, 32'hFFFF_FFFF, q);
        rchk("unmapped", 8'h3C, 32'h0);
        wr_s(`TCS_OFF_PER, 32'h1234);
        rchk("per", `TCS_OFF_PER, 32'h1234);
        wr_s(`TCS_OFF_PERIOD_VALUE_BUFFER, 32'h0055);
        wr_s(`TCS_OFF_CCBUF0, 32'h0AAA);
        wr_s(`TCS_OFF_CCBUF1, 32'h0321);
        wr_s(`TCS_OFF_OUTPUT_PATTERN_BUFFER, 32'h000A_5A3C);
        rchk("period_value_buffer", `TCS_OFF_PERIOD_VALUE_BUFFER, 32'h0055);
        check("per_kept", 32'h1234, {16'h0, period_value});
        wr_s(`TCS_OFF_CMD_SET, 32'h60);
        check("upd_per", 32'h0055, {16'h0, period_value});
        check("upd_cc0", 32'h0AAA, {16'h0, cc0});
        check("upd_cc1", 32'h0321, {16'h0, cc1});
        check("upd_output_pattern", 32'hA5A3C, {12'h0, output_swap, pattern_value, pattern_output});
        rchk("cmd_reads0", `TCS_OFF_CMD_SET, 32'h0);
        wr_s(`TCS_OFF_CMD_SET, 32'h02);
        rchk("lock_clr_view", `TCS_OFF_CMD_CLR, 32'h02);
        wr_s(`TCS_OFF_PERIOD_VALUE_BUFFER, 32'h0777);
        fire(1'b1);
        check("locked_per", 32'h0055, {16'h0, period_value});
        wr_s(`TCS_OFF_CMD_CLR, 32'h02);
        rchk("unlocked", `TCS_OFF_CMD_SET, 32'h0);
        fire(1'b1);
        check("hw_upd_per", 32'h0777, {16'h0, period_value});
        wr_s(`TCS_OFF_CMD_SET, 32'h02);
        wr_s(`TCS_OFF_CONTROL_A_REG, 32'h04);
        check("capt_en", 32'h1, {31'h0, cnt_capture_en});
        wr_s(`TCS_OFF_PERIOD_VALUE_BUFFER, 32'h0888);
        fire(1'b1);
        check("capt_per", 32'h0888, {16'h0, period_value});
        wr_s(`TCS_OFF_CONTROL_A_REG, 32'h0);
        wr_s(`TCS_OFF_CMD_CLR, 32'h02);
        wr_s(`TCS_OFF_CONTROL_A_REG, 32'h02);
        check("enable", 32'h1, {31'h0, cnt_enable});
        wr_s(`TCS_OFF_CMD_SET, 32'h20);
        check("retrig", 32'h1, {31'h0, cnt_running});
        fire(1'b0);
        check("wrap_cont", 32'h1, {31'h0, cnt_running});
        wr_s(`TCS_OFF_CMD_SET, 32'h04);
        wr_s(`TCS_OFF_CMD_SET, 32'h00);
        rchk("single_run_bit", `TCS_OFF_CMD_SET, 32'h04);
        fire(1'b0);
        check("single_run_bit_stop", 32'h0, {31'h0, cnt_running});
        bus(`TCS_OFF_STATUS, 1'b0, 32'h0, q);
        check("done", 32'h4, q & 32'h4);
        wr_s(`TCS_OFF_CMD_CLR, 32'h04);
        rchk("single_run_bit_clr", `TCS_OFF_CMD_SET, 32'h0);
        wr_s(`TCS_OFF_CMD_SET, 32'h20);
        check("retrig_again", 32'h1, {31'h0, cnt_running});
        wr_s(`TCS_OFF_CMD_SET, 32'h40);
        check("stop", 32'h0, {31'h0, cnt_running});
        wr_s(`TCS_OFF_COUNT, 32'hBEEF);
        check("load_val", 32'hBEEF, {16'h0, load_val});
        count_in <= 16'h1111;
        wr_s(`TCS_OFF_CMD_SET, 32'h80);
        rchk("count", `TCS_OFF_COUNT, 32'h1111);
        count_in <= 16'h2222;
        repeat (8) @(posedge ref_clk);
        rchk("count_held", `TCS_OFF_COUNT, 32'h1111);
        wr_s(`TCS_OFF_CMD_SET, 32'h08);
        fire(1'b1);
        check("idx_single", 32'h0, {31'h0, cycle_select_flag});
        wr_s(`TCS_OFF_CMD_SET, 32'h00);
        rchk("idx_pending", `TCS_OFF_CMD_SET, 32'h08);
        wr_s(`TCS_OFF_WAVE, {29'h0, `TCS_WAVE_DUAL_RAMP_MODE});
        fire(1'b1);
        check("idx_dual_ramp_mode", 32'h1, {31'h0, cycle_select_flag});
        rchk("idx_cleared", `TCS_OFF_CMD_SET, 32'h0);
        wr_s(`TCS_OFF_WAVE, {29'h0, `TCS_WAVE_DUAL_RAMP_ALT_MODE});
        rchk("wave", `TCS_OFF_WAVE, 32'h5);
        for (k = 0; k < 4; k++)
        begin
            if (idx_code[k] != 2'h0)
                wr_s(`TCS_OFF_CMD_SET, {27'h0, idx_code[k], 3'h0});
            fire(1'b1);
            check("idx_code", {31'h0, idx_exp[k]}, {31'h0, cycle_select_flag});
        end
        wr_s(`TCS_OFF_CMD_SET, 32'h04);
        wr_s(`TCS_OFF_CONTROL_A_REG, 32'h01);
        check("soft_reset_bit_en", 32'h0, {31'h0, cnt_enable});
        rchk("soft_reset_bit_set", `TCS_OFF_CMD_SET, 32'h0);
        check("hresp", 32'h0, {31'h0, hresp});
        conclude();
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
